// ### design/sbh_device.sv
// device end: serial slave with busy and ready handshake
// Operation
// - ready low only for busy instructions, preset, power-up restore
// - store instructions hold ready low store time
// - read instructions hold ready low read time
// - ready falls within limit after cs rise
// - host waits ready high before cs fall
// - host spaces cs rises four clocks
// - host stops clock before raising cs
// - data captured on rising clock edge
// - preset pulse reloads wipers, ready low
// - power-up restores wipers from storage
// - host waits on ready, not delay
// - host sends nop after restore instruction (sbh_host does not send it; the caller must)
module sbh_device (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	sbh_if.dev_mp             link,
	output logic [9:0]        wiper1_out,
	output logic [9:0]        wiper2_out,
	output logic [3:0]        last_cmd_out,
	output logic              frame_done_out
);
	// ----
	// state record
	// ----
	typedef struct packed {
		logic [1:0]                        cs_sy;
		logic [1:0]                        ck_sy;
		logic [1:0]                        di_sy;
		logic [1:0]                        pr_sy;
		logic                              ck_prev;
		logic                              cs_prev;
		logic [sbh_pkg::FRAME_BITS-1:0]    shreg;
		logic [5:0]                        nbits;
		logic [3:0]                        pend_cmd;
		logic [sbh_pkg::CNT_W-1:0]         cnt;
		logic [sbh_pkg::CNT_W-1:0]         busy_len;
		logic [1:0]                        pr_low;
		logic                              reload;
		logic                              ready;
		logic [9:0]                        w1;
		logic [9:0]                        w2;
		logic [9:0]                        nv1;
		logic [9:0]                        nv2;
		logic [3:0]                        last_cmd;
		logic                              done;
		sbh_pkg::sbh_dev_state_type        state;
	} sbh_dev_reg_type;

	// ----
	// state and decode
	// ----
	sbh_dev_reg_type r_ff;
	sbh_dev_reg_type nxt_r;

	logic cs_n_s;
	logic ck_rise;
	logic cs_rise;
	logic [3:0] cmd;
	logic [3:0] addr;
	logic [9:0] data;

	// ----
	// next state
	// ----
	always_comb begin
		cs_n_s  = r_ff.cs_sy[1];
		ck_rise = r_ff.ck_sy[1] & ~r_ff.ck_prev;
		cs_rise = cs_n_s & ~r_ff.cs_prev;
		cmd     = r_ff.shreg[sbh_pkg::CMD_MSB:sbh_pkg::CMD_LSB];
		addr    = r_ff.shreg[sbh_pkg::ADDR_MSB:sbh_pkg::ADDR_LSB];
		data    = r_ff.shreg[sbh_pkg::DATA_BITS-1:0];
		nxt_r = r_ff;
		nxt_r.cs_sy   = {r_ff.cs_sy[0], link.cs_n};
		nxt_r.ck_sy   = {r_ff.ck_sy[0], link.sclk};
		nxt_r.di_sy   = {r_ff.di_sy[0], link.sdi};
		nxt_r.pr_sy   = {r_ff.pr_sy[0], link.preset_strobe_n};
		nxt_r.ck_prev = r_ff.ck_sy[1];
		nxt_r.cs_prev = cs_n_s;
		nxt_r.done    = 1'b0;
		// capture on rising clock whatever the host phase
		if (!cs_n_s && ck_rise) begin
			nxt_r.shreg = {r_ff.shreg[sbh_pkg::FRAME_BITS-2:0], r_ff.di_sy[1]};
			if (r_ff.nbits != 6'h3F) begin
				nxt_r.nbits = r_ff.nbits + 6'h01;
			end
		end
		// bit count cleared while deselected, only the second sync stage is read
		if (cs_n_s) begin
			nxt_r.nbits = 6'h00;
		end
		// count consecutive low preset samples
		if (!r_ff.pr_sy[1]) begin
			if (r_ff.pr_low != 2'h3) begin
				nxt_r.pr_low = r_ff.pr_low + 2'h1;
			end
		end else begin
			nxt_r.pr_low = 2'h0;
		end
		// short frames are dropped
		if (cs_rise && r_ff.nbits >= 6'(sbh_pkg::FRAME_BITS)) begin
			nxt_r.last_cmd = cmd;
			nxt_r.done     = 1'b1;
			if (cmd == sbh_pkg::CMD_WRITE) begin
				if (addr[0]) begin
					nxt_r.w2 = data;
				end else begin
					nxt_r.w1 = data;
				end
			end
			if (cmd == sbh_pkg::CMD_RESTORE) begin
				nxt_r.w1 = r_ff.nv1;
				nxt_r.w2 = r_ff.nv2;
			end
		end
		unique case (r_ff.state)
			sbh_pkg::SBH_IDLE: begin
				nxt_r.ready = 1'b1;
				if (r_ff.pr_low >= 2'(sbh_pkg::PRESET_MIN_CYC)) begin
					// preset reload
					nxt_r.ready    = 1'b0;
					nxt_r.reload   = 1'b1;
					nxt_r.cnt      = '0;
					nxt_r.busy_len = sbh_pkg::CNT_W'(sbh_pkg::PRESET_CYC);
					nxt_r.state    = sbh_pkg::SBH_BUSY;
				end else if (cs_rise && r_ff.nbits >= 6'(sbh_pkg::FRAME_BITS)) begin
					nxt_r.pend_cmd = cmd;
					nxt_r.cnt      = '0;
					unique case (cmd)
						// store timing
						sbh_pkg::CMD_STORE, sbh_pkg::CMD_STORE_USER: begin
							nxt_r.busy_len = sbh_pkg::CNT_W'(sbh_pkg::STORE_CYC);
							nxt_r.state    = sbh_pkg::SBH_LEAD;
						end
						// read timing
						sbh_pkg::CMD_READ_USER: begin
							nxt_r.busy_len = sbh_pkg::CNT_W'(sbh_pkg::READ8_CYC);
							nxt_r.state    = sbh_pkg::SBH_LEAD;
						end
						sbh_pkg::CMD_READ_WIPER, sbh_pkg::CMD_READ_TOL: begin
							nxt_r.busy_len = sbh_pkg::CNT_W'(sbh_pkg::READ_CYC);
							nxt_r.state    = sbh_pkg::SBH_LEAD;
						end
						default: begin
							nxt_r.state = sbh_pkg::SBH_IDLE;
						end
					endcase
				end
			end
			sbh_pkg::SBH_LEAD: begin
				// ready falls one typical lead after cs rise
				nxt_r.cnt = r_ff.cnt + 1'b1;
				if (r_ff.cnt >= sbh_pkg::CNT_W'(sbh_pkg::CS_BUSY_CYC - 1)) begin
					nxt_r.cnt   = '0;
					nxt_r.ready = 1'b0;
					nxt_r.state = sbh_pkg::SBH_BUSY;
				end
			end
			sbh_pkg::SBH_BUSY: begin
				nxt_r.ready = 1'b0;
				nxt_r.cnt   = r_ff.cnt + 1'b1;
				if (r_ff.cnt >= r_ff.busy_len - 1'b1) begin
					nxt_r.ready  = 1'b1;
					nxt_r.state  = sbh_pkg::SBH_IDLE;
					nxt_r.reload = 1'b0;
					if (r_ff.reload) begin
						// power-up restore and preset reload
						nxt_r.w1 = r_ff.nv1;
						nxt_r.w2 = r_ff.nv2;
					end else if (r_ff.pend_cmd == sbh_pkg::CMD_STORE) begin
						// only the plain store copies wipers to storage
						nxt_r.nv1 = r_ff.w1;
						nxt_r.nv2 = r_ff.w2;
					end
				end
			end
			default: nxt_r.state = sbh_pkg::SBH_IDLE;
		endcase
	end

	// ----
	// registers
	// ----
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			r_ff          <= '0;
			r_ff.cs_sy    <= 2'b11;
			r_ff.cs_prev  <= 1'b1;
			r_ff.pr_sy    <= 2'b11;
			r_ff.nv1      <= 10'(sbh_pkg::WIPER_RESET);
			r_ff.nv2      <= 10'(sbh_pkg::WIPER_RESET);
			// power-on restore runs busy first
			r_ff.reload   <= 1'b1;
			r_ff.busy_len <= sbh_pkg::CNT_W'(sbh_pkg::RESTORE_CYC);
			r_ff.state    <= sbh_pkg::SBH_BUSY;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ----
	// outputs
	// ----
	assign link.ready     = r_ff.ready;
	assign wiper1_out     = r_ff.w1;
	assign wiper2_out     = r_ff.w2;
	assign last_cmd_out   = r_ff.last_cmd;
	assign frame_done_out = r_ff.done;
endmodule

// ### design/sbh_host.sv
// host end: serial master that waits on ready between frames
module sbh_host (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	sbh_if.host_mp            link,
	input  wire logic         req_valid_in,
	input  wire logic [23:0]  req_frame_in,
	input  wire logic         preset_req_in,
	output logic              req_ready_out,
	output logic              busy_out
);
	// ----
	// state record
	// ----
	typedef struct packed {
		logic [1:0]                         rdy_sy;
		logic [23:0]                        shreg;
		logic [5:0]                         nbits;
		logic [sbh_pkg::DIV_W-1:0]          div;
		logic [2:0]                         gap;
		logic [1:0]                         prcnt;
		logic                               cs_n;
		logic                               sclk;
		logic                               sdi;
		logic                               pr_n;
		sbh_pkg::sbh_host_state_type        state;
	} sbh_host_reg_type;

	localparam logic [sbh_pkg::DIV_W-1:0] HALF = sbh_pkg::DIV_W'(sbh_pkg::SCLK_HALF_CYC);

	sbh_host_reg_type r_ff;
	sbh_host_reg_type nxt_r;
	logic tick;

	// ----
	// next state
	// ----
	always_comb begin
		tick  = (r_ff.div == HALF - 8'h01);
		nxt_r = r_ff;
		nxt_r.rdy_sy = {r_ff.rdy_sy[0], link.ready};
		nxt_r.div    = tick ? 8'h00 : r_ff.div + 8'h01;
		req_ready_out = (r_ff.state == sbh_pkg::SBH_H_IDLE) && r_ff.pr_n;
		if (r_ff.prcnt != 2'h0) begin
			nxt_r.prcnt = r_ff.prcnt - 2'h1;
		end else begin
			nxt_r.pr_n = 1'b1;
		end
		unique case (r_ff.state)
			sbh_pkg::SBH_H_IDLE: begin
				if (preset_req_in && r_ff.pr_n) begin
					nxt_r.pr_n  = 1'b0;
					nxt_r.prcnt = 2'(sbh_pkg::PRESET_MIN_CYC + 1);
				end else if (req_valid_in && r_ff.pr_n) begin
					nxt_r.shreg = req_frame_in;
					nxt_r.state = sbh_pkg::SBH_H_WAITR;
				end
			end
			sbh_pkg::SBH_H_WAITR: begin
				// wait on ready, never a fixed delay
				if (r_ff.rdy_sy[1] && tick) begin
					nxt_r.cs_n  = 1'b0;
					nxt_r.sdi   = r_ff.shreg[23];
					nxt_r.nbits = 6'h00;
					nxt_r.state = sbh_pkg::SBH_H_SHIFT;
				end
			end
			sbh_pkg::SBH_H_SHIFT: begin
				if (tick) begin
					nxt_r.sclk = ~r_ff.sclk;
					if (r_ff.sclk) begin
						// change data on falling edge, valid at rise
						nxt_r.shreg = {r_ff.shreg[22:0], 1'b0};
						nxt_r.sdi   = r_ff.shreg[22];
					end else begin
						nxt_r.nbits = r_ff.nbits + 6'h01;
						if (r_ff.nbits == 6'h17) begin
							nxt_r.gap   = 3'h0;
							nxt_r.state = sbh_pkg::SBH_H_STOP;
						end
					end
				end
			end
			sbh_pkg::SBH_H_STOP: begin
				// clock idles before cs rises
				if (tick) begin
					nxt_r.sclk = 1'b0;
					nxt_r.gap  = r_ff.gap + 3'h1;
					if (r_ff.gap == 3'(2 * sbh_pkg::CLK_STOP_CYC)) begin
						nxt_r.cs_n  = 1'b1;
						nxt_r.gap   = 3'h0;
						nxt_r.state = sbh_pkg::SBH_H_GAP;
					end
				end
			end
			sbh_pkg::SBH_H_GAP: begin
				// space cs rises apart
				if (tick) begin
					nxt_r.gap = r_ff.gap + 3'h1;
					if (r_ff.gap == 3'(2 * sbh_pkg::FRAME_GAP_CYC - 1)) begin
						nxt_r.state = sbh_pkg::SBH_H_IDLE;
					end
				end
			end
			default: nxt_r.state = sbh_pkg::SBH_H_IDLE;
		endcase
	end

	// ----
	// registers
	// ----
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			r_ff      <= '0;
			r_ff.cs_n <= 1'b1;
			r_ff.pr_n <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ----
	// outputs
	// ----
	assign link.cs_n            = r_ff.cs_n;
	assign link.sclk            = r_ff.sclk;
	assign link.sdi             = r_ff.sdi;
	assign link.preset_strobe_n = r_ff.pr_n;
	assign busy_out             = ~r_ff.rdy_sy[1];
	// nop after restore is the caller's duty
endmodule

// ### inc/sbh_if.sv
// link wires between host and potentiometer device
interface sbh_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic ready;
	logic preset_strobe_n;
	modport host_mp (output cs_n, output sclk, output sdi, output preset_strobe_n, input ready);
	modport dev_mp (input cs_n, input sclk, input sdi, input preset_strobe_n, output ready);
endinterface

// ### inc/sbh_pkg.sv
// shared constants and types for the serial busy handshake link
package sbh_pkg;
	localparam int unsigned CLK_PERIOD_NS      = 25;
	// timing figures as printed
	localparam int unsigned STORE_TIME_MS      = 15;
	localparam int unsigned STORE_MAX_MS       = 50;
	localparam int unsigned READ_TIME_US       = 7;
	localparam int unsigned READ_MAX_US        = 30;
	localparam int unsigned READ8_TIME_US      = 20;
	localparam int unsigned PRESET_TIME_US     = 30;
	localparam int unsigned RESTORE_TIME_US    = 30;
	localparam int unsigned CS_TO_BUSY_US      = 150;
	localparam int unsigned PRESET_MIN_NS      = 50;
	localparam int unsigned FRAME_GAP_CYC      = 4;
	localparam int unsigned CLK_STOP_CYC       = 1;
	localparam int unsigned SCLK_HALF_CYC      = 4;
	// derived cycle counts
	localparam int unsigned STORE_CYC   = STORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned READ_CYC    = READ_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned READ8_CYC   = READ8_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned PRESET_CYC  = PRESET_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned RESTORE_CYC = RESTORE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CS_BUSY_CYC = CS_TO_BUSY_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned PRESET_MIN_CYC = (PRESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// frame layout
	localparam int unsigned FRAME_BITS  = 24;
	localparam int unsigned CMD_MSB     = 23;
	localparam int unsigned CMD_LSB     = 20;
	localparam int unsigned ADDR_MSB    = 19;
	localparam int unsigned ADDR_LSB    = 16;
	localparam int unsigned DATA_BITS   = 10;
	localparam int unsigned WIPER_RESET = 512;
	localparam int unsigned CNT_W       = 24;
	localparam int unsigned DIV_W       = 8;
	// instruction codes
	localparam logic [3:0] CMD_NOP        = 4'h0;
	localparam logic [3:0] CMD_RESTORE    = 4'h1;
	localparam logic [3:0] CMD_STORE      = 4'h2;
	localparam logic [3:0] CMD_STORE_USER = 4'h3;
	localparam logic [3:0] CMD_READ_USER  = 4'h8;
	localparam logic [3:0] CMD_READ_WIPER = 4'h9;
	localparam logic [3:0] CMD_READ_TOL   = 4'hA;
	localparam logic [3:0] CMD_WRITE      = 4'hB;
	// device busy phases
	typedef enum logic [1:0] {
		SBH_IDLE    = 2'b00,
		SBH_LEAD    = 2'b01,
		SBH_BUSY    = 2'b10
	} sbh_dev_state_type;
	// host phases
	typedef enum logic [2:0] {
		SBH_H_IDLE  = 3'b000,
		SBH_H_WAITR = 3'b001,
		SBH_H_SHIFT = 3'b010,
		SBH_H_STOP  = 3'b011,
		SBH_H_GAP   = 3'b100
	} sbh_host_state_type;
endpackage

// ### test/sbh_monitor.sv
// link wire assertions for the busy handshake
module sbh_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic ready,
	input wire logic preset_strobe_n
);
	localparam int LIM = 12000;
	typedef struct packed {
		logic        sq, cq, pr, fell, done;
		logic [3:0]  cmd, quiet;
		logic [23:0] sh, since, low;
	} sbh_mon_type;
	sbh_mon_type s_ff, nxt_s;
	int          rd_t;
	function automatic logic busy_f(input logic [3:0] c);
		return c inside {4'h2, 4'h3, 4'h8, 4'h9, 4'hA};
	endfunction
	// ----
	// wire history
	// ----
	assign rd_t = (s_ff.cmd == 4'h8) ? int'(sbh_pkg::READ8_CYC) : int'(sbh_pkg::READ_CYC);
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sq = sclk;
		nxt_s.cq = cs_n;
		nxt_s.low = ready ? 24'h0 : s_ff.low + 24'h1;
		nxt_s.quiet = (sclk != s_ff.sq) ? 4'h0 : s_ff.quiet + 4'(s_ff.quiet != 4'hF);
		nxt_s.since = s_ff.since + 24'(s_ff.since <= LIM);
		nxt_s.fell = s_ff.fell | ~ready;
		nxt_s.pr = s_ff.pr | ~preset_strobe_n;
		nxt_s.done = s_ff.done | ready;
		if (sclk && !s_ff.sq && !cs_n) begin
			nxt_s.sh = {s_ff.sh[22:0], sdi};
		end
		if (cs_n && !s_ff.cq) begin
			nxt_s.cmd = s_ff.sh[23:20];
			nxt_s.since = 24'h0;
			nxt_s.fell = 1'b0;
			nxt_s.pr = 1'b0;
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s_ff <= '0;
			s_ff.cq <= 1'b1;
			s_ff.since <= 24'(LIM + 1);
		end else begin
			s_ff <= nxt_s;
		end
	end
	// ----
	// checks
	// ----
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_busy_cmds_only: assert property ($fell(ready) |-> s_ff.pr || (busy_f(s_ff.cmd) && s_ff.since <= LIM))
		else $error("ready fell without a busy cause");
	a_store_max_low: assert property (s_ff.low <= 24'h1E8480)
		else $error("ready low beyond store limit");
	a_read_hold_time: assert property (
		$rose(ready) && s_ff.done && !s_ff.pr && s_ff.cmd inside {4'h8, 4'h9, 4'hA}
		|-> s_ff.low + 8 >= rd_t && s_ff.low <= rd_t + 8) else $error("read busy span off");
	a_ready_fall_late: assert property (busy_f(s_ff.cmd) && s_ff.since == LIM && !s_ff.pr |-> s_ff.fell)
		else $error("ready did not fall in time");
	a_cs_after_ready: assert property ($fell(cs_n) |-> ready)
		else $error("frame started while busy");
	a_cs_rise_gap: assert property ($rose(cs_n) |-> s_ff.since >= 31)
		else $error("frame ends too close");
	a_clock_stop: assert property ($rose(cs_n) |-> s_ff.quiet >= 4'h7)
		else $error("clock not stopped before frame end");
	a_data_on_low: assert property ($changed(sdi) && !cs_n |-> !sclk)
		else $error("data moved while clock high");
	a_preset_hold: assert property (
		$rose(ready) && s_ff.done && s_ff.pr
		|-> s_ff.low + 8 >= sbh_pkg::PRESET_CYC && s_ff.low <= sbh_pkg::PRESET_CYC + 8) else $error("preset span off");
	a_restore_span: assert property (
		$rose(ready) && !s_ff.done
		|-> s_ff.low + 8 >= sbh_pkg::RESTORE_CYC && s_ff.low <= sbh_pkg::RESTORE_CYC + 8) else $error("restore span off");
	a_nonbusy_high: assert property ($rose(cs_n) && ready && !busy_f(s_ff.sh[23:20]) |=> ready [*8])
		else $error("ready dropped after plain frame");
	c_read: cover property ($rose(ready) && s_ff.cmd == 4'h9);
	c_preset: cover property ($rose(ready) && s_ff.pr);
	c_write: cover property ($rose(cs_n) && s_ff.sh[23:20] == 4'hB);
endmodule

// ### test/serial_busy_handshake_timing_test.sv
// bench joining host and device ends
module serial_busy_handshake_timing_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        req_valid = 1'b0;
	logic [23:0] req_frame = 24'h0;
	logic        preset_req = 1'b0;
	logic        req_ready, busy, done, done_b;
	logic [9:0]  w1, w2, w1b, w2b;
	logic [3:0]  cmd, cmd_b;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cnt;
	sbh_if link_a ();
	sbh_if link_b ();
	always #12.5 clk_sys_in = ~clk_sys_in;
	sbh_host i_sbh_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link_a), .req_valid_in(req_valid),
		.req_frame_in(req_frame), .preset_req_in(preset_req), .req_ready_out(req_ready), .busy_out(busy));
	sbh_device i_sbh_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link_a), .wiper1_out(w1),
		.wiper2_out(w2), .last_cmd_out(cmd), .frame_done_out(done));
	sbh_device i_sbh_device_b (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link_b), .wiper1_out(w1b),
		.wiper2_out(w2b), .last_cmd_out(cmd_b), .frame_done_out(done_b));
	sbh_monitor i_sbh_monitor (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n(link_a.cs_n), .sclk(link_a.sclk),
		.sdi(link_a.sdi), .ready(link_a.ready), .preset_strobe_n(link_a.preset_strobe_n));
	// ----
	// helpers
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic in_range(input int v, input int lo, input int hi);
		check(24'(v >= lo && v <= hi), 24'h1);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic do_reset();
		rst_in = 1'b1;
		tick(5);
		rst_in = 1'b0;
	endtask
	task automatic wait_rdy(input logic lvl, input int lim, output int n);
		n = 0;
		while (link_a.ready !== lvl && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [9:0] d, input bit wd);
		logic ok;
		int   n;
		req_frame = {c, a, 6'h0, d};
		req_valid = 1'b1;
		n = 0;
		do begin
			ok = req_ready;
			tick(1);
			n++;
		end while (ok !== 1'b1 && n < 100);
		req_valid = 1'b0;
		check(24'(ok), 24'h1);
		n = 0;
		while (wd && done !== 1'b1 && n < 15000) begin
			tick(1);
			n++;
		end
		if (wd) begin
			check(24'(done), 24'h1);
		end
	endtask
	// raw frame on the second link, either clock idle level
	task automatic raw(input logic [23:0] f, input int nb, input logic idle);
		link_b.sclk = idle;
		tick(4);
		link_b.cs_n = 1'b0;
		tick(4);
		for (int i = 0; i < nb; i++) begin
			link_b.sclk = 1'b0;
			link_b.sdi = f[23 - i];
			tick(4);
			link_b.sclk = 1'b1;
			tick(4);
		end
		link_b.sclk = idle;
		tick(8);
		link_b.cs_n = 1'b1;
		link_b.sdi = ~link_b.sdi;
		tick(40);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_power();
		wait_rdy(1'b1, 2000, cnt);
		in_range(cnt, sbh_pkg::RESTORE_CYC - 8, sbh_pkg::RESTORE_CYC + 8);
		check(24'(w1), 24'(sbh_pkg::WIPER_RESET));
		check(24'(w2), 24'(sbh_pkg::WIPER_RESET));
		tick(20);
		check(24'(link_a.ready), 24'h1);
		$display("test power done");
	endtask
	task automatic t_phase();
		raw({sbh_pkg::CMD_WRITE, 10'h0, 10'h3A5}, 24, 1'b1);
		check(24'(w1b), 24'h3A5);
		check(24'(cmd_b), 24'(sbh_pkg::CMD_WRITE));
		raw({sbh_pkg::CMD_WRITE, 10'h040, 10'h0CC}, 24, 1'b0);
		check(24'(w2b), 24'h0CC);
		raw({sbh_pkg::CMD_WRITE, 10'h0, 10'h111}, 20, 1'b0);
		check(24'(w1b), 24'h3A5);
		check(24'(link_b.ready), 24'h1);
		$display("test phase done");
	endtask
	task automatic t_write();
		send(sbh_pkg::CMD_WRITE, 4'h0, 10'h2A5, 1'b1);
		send(sbh_pkg::CMD_WRITE, 4'h1, 10'h15A, 1'b1);
		check(24'(w1), 24'h2A5);
		check(24'(w2), 24'h15A);
		send(sbh_pkg::CMD_RESTORE, 4'h0, 10'h0, 1'b1);
		send(sbh_pkg::CMD_NOP, 4'h0, 10'h0, 1'b1);
		check(24'(cmd), 24'(sbh_pkg::CMD_NOP));
		tick(300);
		check(24'(link_a.ready), 24'h1);
		$display("test write done");
	endtask
	task automatic t_read(input logic [3:0] c, input int t);
		send(c, 4'h0, 10'h0, 1'b1);
		wait_rdy(1'b0, 13000, cnt);
		in_range(cnt, 0, 12000);
		wait_rdy(1'b1, 2000, cnt);
		in_range(cnt, t - 8, t + 8);
		check(24'(cmd), 24'(c));
		$display("test read %h done", c);
	endtask
	task automatic t_preset();
		send(sbh_pkg::CMD_WRITE, 4'h0, 10'h0C3, 1'b1);
		send(sbh_pkg::CMD_WRITE, 4'h1, 10'h0C4, 1'b1);
		check(24'(w2), 24'h0C4);
		cnt = 0;
		while (req_ready !== 1'b1 && cnt < 100) begin
			tick(1);
			cnt++;
		end
		check(24'(req_ready), 24'h1);
		preset_req = 1'b1;
		tick(4);
		preset_req = 1'b0;
		wait_rdy(1'b0, 40, cnt);
		check(24'(link_a.ready), 24'h0);
		wait_rdy(1'b1, 2000, cnt);
		in_range(cnt, sbh_pkg::PRESET_CYC - 8, sbh_pkg::PRESET_CYC + 8);
		check(24'(w1), 24'(sbh_pkg::WIPER_RESET));
		check(24'(w2), 24'(sbh_pkg::WIPER_RESET));
		$display("test preset done");
	endtask
	task automatic t_store(input logic [3:0] c);
		send(c, 4'h0, 10'h0, 1'b1);
		wait_rdy(1'b0, 13000, cnt);
		in_range(cnt, 0, 12000);
		send(sbh_pkg::CMD_WRITE, 4'h0, 10'h0, 1'b0);
		tick(2000);
		check(24'(link_a.ready), 24'h0);
		check(24'(busy), 24'h1);
		check(24'(link_a.cs_n), 24'h1);
		do_reset();
		t_power();
		$display("test store %h done", c);
	endtask
	initial begin
		link_b.cs_n = 1'b1;
		link_b.sclk = 1'b0;
		link_b.sdi = 1'b0;
		link_b.preset_strobe_n = 1'b1;
		do_reset();
		t_power();
		t_phase();
		t_write();
		t_read(sbh_pkg::CMD_READ_USER, sbh_pkg::READ8_CYC);
		t_read(sbh_pkg::CMD_READ_WIPER, sbh_pkg::READ_CYC);
		t_read(sbh_pkg::CMD_READ_TOL, sbh_pkg::READ_CYC);
		t_preset();
		t_store(sbh_pkg::CMD_STORE);
		t_store(sbh_pkg::CMD_STORE_USER);
		give_verdict();
	end
	initial begin
		#2000000;
		n_errors++;
		$display("Error at %0t ns: watchdog expired", $time);
		give_verdict();
	end
endmodule
